// [core/hsfp_pkg.sv]
// Shared types and constants of the high-side fault protection block.
// Assumes a 200 MHz core clock and word-wide AHB-Lite register access.
package hsfp_pkg;

  localparam int NCH     = 2;
  localparam int CLK_MHZ = 200;
  localparam int DUR_W   = 16;
  localparam int CNT_W   = 24;
  localparam int RET_W   = 4;
  localparam int SC_W    = 8;
  localparam int ADDR_W  = 8;

  // Turn-on interval in which a hard short is judged severe
  localparam int               SC_DETECT_NS  = 1000;
  localparam logic [SC_W-1:0]  SC_DETECT_CYC = SC_W'((SC_DETECT_NS * CLK_MHZ + 999) / 1000);
  // Pause between a fault and the next automatic turn-on
  localparam int               RETRY_WAIT_US  = 10000;
  localparam logic [CNT_W-1:0] RETRY_WAIT_DEF = CNT_W'(RETRY_WAIT_US * CLK_MHZ);
  // Longest switching period that still counts as switch mode
  localparam int               PWM_MAX_PERIOD_US = 10000;
  localparam logic [CNT_W-1:0] PWM_MAX_DEF       = CNT_W'(PWM_MAX_PERIOD_US * CLK_MHZ);

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_GCR     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_WIN     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DELATCH = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h0c;

  // Reset values
  localparam logic [RET_W-1:0] RETRY_LIMIT_RST = 4'h3;
  localparam logic [DUR_W-1:0] WIN_HI_RST      = 16'h0fa0;
  localparam logic [DUR_W-1:0] WIN_MID_RST     = 16'h9c40;

  typedef enum logic [1:0] {
    CH_OFF   = 2'b00,
    CH_ON    = 2'b01,
    CH_RETRY = 2'b11,
    CH_LATCH = 2'b10
  } hsfp_chst_e;

  typedef enum logic [1:0] {
    PH_NONE   = 2'b00,
    PH_HIGH   = 2'b01,
    PH_MID    = 2'b11,
    PH_STEADY = 2'b10
  } hsfp_phase_e;

  typedef struct packed {
    logic [NCH-1:0] on_cmd;
    logic [NCH-1:0] oc_high;
    logic [NCH-1:0] oc_mid;
    logic [NCH-1:0] oc_low;
    logic [NCH-1:0] sc;
    logic [NCH-1:0] ot;
    logic [NCH-1:0] profile;
    logic           ov;
    logic           ov_release;
    logic           uv;
    logic           logic_loss;
  } hsfp_pins_s;

  // general_config_register
  typedef struct packed {
    logic [23:0]    rsv_hi;
    logic [RET_W-1:0] retry_limit;
    logic           rsv_lo;
    logic [NCH-1:0] retry_en;
    logic           overvoltage_protect_disable;
  } hsfp_gcr_s;

  typedef struct packed {
    logic [DUR_W-1:0] middle_window_width;
    logic [DUR_W-1:0] high_window_width;
  } hsfp_win_s;

  // device_status_register
  typedef struct packed {
    logic [11:0]      rsv;
    logic [RET_W-1:0] retries1;
    logic [RET_W-1:0] retries0;
    logic [NCH-1:0]   switch_mode;
    logic [NCH-1:0]   ch_on;
    logic [NCH-1:0]   overtemp_flag;
    logic [NCH-1:0]   short_circuit_flag;
    logic [NCH-1:0]   overcurrent_flag;
    logic             undervoltage_flag;
    logic             overvoltage_flag;
  } hsfp_status_s;

  typedef struct packed {
    hsfp_chst_e       st;
    hsfp_phase_e      phase;
    logic [DUR_W-1:0] dur;
    logic [SC_W-1:0]  sc_cnt;
    logic [CNT_W-1:0] retry_tmr;
    logic [CNT_W-1:0] pwm_cnt;
    logic [RET_W-1:0] retries;
    logic             cmd_prev;
    logic             switch_mode;
    logic             first_done;
    logic             oc_seen;
    logic             retry_turnon;
    logic             uv_cause;
    logic             oc;
    logic             sc;
    logic             ot;
    logic             out_on;
    logic             sync;
  } hsfp_chan_s;

  typedef struct packed {
    hsfp_pins_s            s1;
    hsfp_pins_s            s2;
    hsfp_chan_s [NCH-1:0]  ch;
    hsfp_gcr_s             general_config_register;
    hsfp_win_s             win;
    logic                  ov;
    logic                  uv;
    logic                  ov_hold;
    logic                  fsb_n;
    logic                  ap_valid;
    logic                  ap_write;
    logic [ADDR_W-1:0]     ap_addr;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  hresp;
  } hsfp_state_s;

endpackage

// [core/hsfp_top.sv]
// Two-channel high-side switch fault protection with an AHB-Lite register slave.
// Assumes comparator and supply monitor levels arrive asynchronously on pins.
//
// What this block does
// - Overcurrent switches the channel off, sets its flag, pulls fault status low.
// - While any overcurrent window is active, sensing is blanked and sync held high.
// - Threshold crossing, or the duration counter in DC motor profile, ends the channel with an overcurrent fault.
// - Profile pin low selects lighting, high selects DC motor profile.
// - Lighting uses high, middle, low thresholds; profile restarts each turn-on.
// - In switch mode the lighting profile starts at first turn-on only.
// - DC motor uses one window opened when current exceeds the low level.
// - With auto-retry, overcurrent latches only after retries are used up.
// - Duty below full at rate above minimum PWM frequency means switch mode.
// - In switch mode the counter accumulates only during on-times.
// - Delatch clears the counter; lighting retries clear it, DC motor retries not.
// - DC motor: clean on-period clears the counter at the following turn-off.
// - Switch mode keeps the counter through PWM; in DC motor profile only delatch clears it.
// - Severe short at turn-on: off at once, fault low, flag set, retry.
// - Overvoltage turns both channels off, fault low, flag set until hysteresis.
// - Overvoltage flag clears on status read after the supply recovered.
// - With protection disabled overvoltage only sets the warning flag.
// - Undervoltage turns channels off, fault low, sets the shared flag.
// - Undervoltage gone with command off: fault high, flag kept until output on or status read.
// - Undervoltage gone with command on: on after delatch or auto-retry; flag clears when the output turns on.
// - Auto-retry begins as soon as undervoltage disappears.
// - Latched faults clear on read after cause gone and delatch, or logic loss.
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

module hsfp_top
  import hsfp_pkg::*;
#(
  parameter logic [CNT_W-1:0] RETRY_WAIT_CYC     = RETRY_WAIT_DEF,
  parameter logic [CNT_W-1:0] PWM_MAX_PERIOD_CYC = PWM_MAX_DEF
)(
  input  wire logic           I_MCLK,
  input  wire logic           I_RST_B,
  input  wire logic           I_HSEL,
  input  wire logic [31:0]    I_HADDR,
  input  wire logic [1:0]     I_HTRANS,
  input  wire logic           I_HWRITE,
  input  wire logic [2:0]     I_HSIZE,
  input  wire logic [31:0]    I_HWDATA,
  input  wire logic           I_HREADY,
  output logic      [31:0]    O_HRDATA,
  output logic                O_HREADYOUT,
  output logic                O_HRESP,
  input  wire logic [NCH-1:0] I_ON_CMD,
  input  wire logic [NCH-1:0] I_LOAD_PROFILE_SELECT,
  input  wire logic [NCH-1:0] I_OC_HIGH,
  input  wire logic [NCH-1:0] I_OC_MID,
  input  wire logic [NCH-1:0] I_OC_LOW,
  input  wire logic [NCH-1:0] I_SEVERE_SHORT,
  input  wire logic [NCH-1:0] I_OVERTEMP,
  input  wire logic           I_SUPPLY_OV,
  input  wire logic           I_SUPPLY_OV_RELEASE,
  input  wire logic           I_SUPPLY_UV,
  input  wire logic           I_LOGIC_SUPPLY_LOSS,
  output logic      [NCH-1:0] O_CH_ON,
  output logic      [NCH-1:0] O_SENSE_SYNC,
  output logic                O_FAULT_STATUS_OUT_N
);

  hsfp_state_s    st;
  hsfp_state_s    nx;
  hsfp_pins_s     pins;
  logic [NCH-1:0] delatch_w;
  logic           rd_status_w;

  assign pins = '{on_cmd: I_ON_CMD, oc_high: I_OC_HIGH, oc_mid: I_OC_MID, oc_low: I_OC_LOW,
                  sc: I_SEVERE_SHORT, ot: I_OVERTEMP, profile: I_LOAD_PROFILE_SELECT,
                  ov: I_SUPPLY_OV, ov_release: I_SUPPLY_OV_RELEASE, uv: I_SUPPLY_UV,
                  logic_loss: I_LOGIC_SUPPLY_LOSS};

  always_comb
  begin
    hsfp_chan_s       c;
    hsfp_status_s     stat;
    logic             wr_now;
    logic             ov_block;
    logic             prof;
    logic             cmd;
    logic             trip;
    logic             latch_fault;
    logic             new_on;
    logic             cnt_en;
    logic             any_on;
    logic             any_latch;
    logic             any_fault;
    logic [DUR_W-1:0] wlim;
    nx          = st;
    c           = st.ch[0];
    wr_now      = 1'b0;
    ov_block    = 1'b0;
    stat        = '0;
    prof        = 1'b0;
    cmd         = 1'b0;
    trip        = 1'b0;
    latch_fault = 1'b0;
    new_on      = 1'b0;
    cnt_en      = 1'b0;
    wlim        = '0;
    any_on      = 1'b0;
    any_latch   = 1'b0;
    any_fault   = 1'b0;

    nx.s1 = pins;
    nx.s2 = st.s1;

    // Bus address phase and data phase
    nx.ap_valid = I_HSEL && I_HTRANS[1] && I_HREADY;
    if (nx.ap_valid)
    begin
      nx.ap_write = I_HWRITE;
      nx.ap_addr  = I_HADDR[ADDR_W-1:0];
    end
    wr_now      = st.ap_valid && st.ap_write;
    rd_status_w = nx.ap_valid && !I_HWRITE && (I_HADDR[ADDR_W-1:0] == ADDR_STATUS);
    delatch_w   = '0;
    if (wr_now && (st.ap_addr == ADDR_GCR))
    begin
      nx.general_config_register        = hsfp_gcr_s'(I_HWDATA);
      nx.general_config_register.rsv_hi = '0;
      nx.general_config_register.rsv_lo = 1'b0;
    end
    if (wr_now && (st.ap_addr == ADDR_WIN))
      nx.win = hsfp_win_s'(I_HWDATA);
    if (wr_now && (st.ap_addr == ADDR_DELATCH))
      delatch_w = I_HWDATA[NCH-1:0];

    stat.overvoltage_flag  = st.ov;
    stat.undervoltage_flag = st.uv;
    stat.retries0          = st.ch[0].retries;
    stat.retries1          = st.ch[1].retries;
    for (int i = 0; i < NCH; i++)
    begin
      stat.overcurrent_flag[i]   = st.ch[i].oc;
      stat.short_circuit_flag[i] = st.ch[i].sc;
      stat.overtemp_flag[i]      = st.ch[i].ot;
      stat.ch_on[i]              = st.ch[i].out_on;
      stat.switch_mode[i]        = st.ch[i].switch_mode;
      any_on    = any_on | st.ch[i].out_on;
      any_latch = any_latch | (st.ch[i].st == CH_LATCH) | (st.ch[i].st == CH_RETRY);
    end
    if (nx.ap_valid && !I_HWRITE)
    begin
      case (I_HADDR[ADDR_W-1:0])
        ADDR_GCR:    nx.hrdata = st.general_config_register;
        ADDR_WIN:    nx.hrdata = st.win;
        ADDR_STATUS: nx.hrdata = stat;
        default:     nx.hrdata = '0;
      endcase
    end

    // Supply overvoltage hold until below threshold minus hysteresis
    ov_block   = !st.general_config_register.overvoltage_protect_disable && (st.s2.ov || st.ov_hold);
    nx.ov_hold = st.s2.ov ? 1'b1 : (st.s2.ov_release ? 1'b0 : st.ov_hold);

    for (int i = 0; i < NCH; i++)
    begin
      c           = st.ch[i];
      prof        = st.s2.profile[i];
      cmd         = st.s2.on_cmd[i];
      trip        = 1'b0;
      latch_fault = 1'b0;
      new_on      = 1'b0;
      cnt_en      = 1'b0;

      // Read clears old flags first so that a new event in this cycle wins
      if (rd_status_w && (c.st != CH_LATCH) && (c.st != CH_RETRY))
      begin
        c.oc = 1'b0;
        c.sc = 1'b0;
        if (!st.s2.ot[i])
          c.ot = 1'b0;
      end
      if (st.s2.ot[i])
        c.ot = 1'b1;

      // Switch mode: command edges closer than the longest PWM period
      if (cmd != c.cmd_prev)
      begin
        if (cmd && (c.pwm_cnt < PWM_MAX_PERIOD_CYC))
          c.switch_mode = 1'b1;
        c.pwm_cnt = '0;
      end
      else if (c.pwm_cnt >= PWM_MAX_PERIOD_CYC)
      begin
        c.switch_mode = 1'b0;
        c.first_done  = 1'b0;
      end
      else
        c.pwm_cnt = c.pwm_cnt + 1'b1;
      c.cmd_prev = cmd;

      wlim = (!prof && (c.phase == PH_HIGH)) ? st.win.high_window_width
                                             : st.win.middle_window_width;

      case (c.st)
        CH_OFF:
        begin
          if (cmd && !ov_block && !st.s2.uv && !st.s2.ot[i])
          begin
            c.st   = CH_ON;
            new_on = 1'b1;
          end
        end
        CH_ON:
        begin
          if (st.s2.sc[i] && (c.sc_cnt != '0))
          begin
            c.sc        = 1'b1;
            latch_fault = 1'b1;
          end
          else if (st.s2.ot[i])
            latch_fault = 1'b1;
          else if (st.s2.uv)
            latch_fault = 1'b1;
          else if (ov_block)
            c.st = CH_OFF;
          else if (!cmd)
          begin
            c.st = CH_OFF;
            if (prof && !c.oc_seen && !c.switch_mode)
              c.dur = '0;
          end
          else
          begin
            // Counter runs only while the channel conducts
            if (prof)
            begin
              cnt_en = st.s2.oc_low[i];
              if (cnt_en)
                c.oc_seen = 1'b1;
              trip = st.s2.oc_high[i];
            end
            else
            begin
              cnt_en = (c.phase == PH_HIGH) || (c.phase == PH_MID);
              trip   = ((c.phase == PH_HIGH) && st.s2.oc_high[i]) ||
                       ((c.phase == PH_MID) && st.s2.oc_mid[i]) ||
                       ((c.phase == PH_STEADY) && st.s2.oc_low[i]);
            end
            if (cnt_en)
            begin
              c.dur = (c.dur == '1) ? c.dur : c.dur + 1'b1;
              if (c.dur >= wlim)
              begin
                if (prof)
                  trip = 1'b1;
                else
                begin
                  c.phase = (c.phase == PH_HIGH) ? PH_MID : PH_STEADY;
                  c.dur   = '0;
                end
              end
            end
            if (trip)
            begin
              c.oc        = 1'b1;
              latch_fault = 1'b1;
            end
          end
          if (c.sc_cnt != '0)
            c.sc_cnt = c.sc_cnt - 1'b1;
        end
        CH_RETRY:
        begin
          if (st.s2.uv || st.s2.ot[i])
            c.retry_tmr = '0;
          else if ((c.retry_tmr >= RETRY_WAIT_CYC) || c.uv_cause)
          begin
            c.retry_turnon = 1'b1;
            if (cmd && !ov_block)
            begin
              c.st   = CH_ON;
              new_on = 1'b1;
            end
            else
              c.st = CH_OFF;
          end
          else
            c.retry_tmr = c.retry_tmr + 1'b1;
        end
        CH_LATCH:
          c.st = CH_LATCH;
        default:
          c.st = CH_OFF;
      endcase

      if (latch_fault)
      begin
        c.uv_cause  = st.s2.uv;
        c.retry_tmr = '0;
        if (st.general_config_register.retry_en[i] && (c.retries != '0))
        begin
          c.st      = CH_RETRY;
          c.retries = c.retries - 1'b1;
        end
        else
          c.st = CH_LATCH;
      end

      if (new_on)
      begin
        c.sc_cnt  = SC_DETECT_CYC;
        c.oc_seen = 1'b0;
        if (prof)
          c.phase = PH_NONE;
        else if (!c.switch_mode || !c.first_done)
        begin
          c.phase = PH_HIGH;
          c.dur   = '0;
        end
        if (c.retry_turnon && !prof)
          c.dur = '0;
        c.retry_turnon = 1'b0;
        c.first_done   = 1'b1;
      end

      if (delatch_w[i])
      begin
        if ((c.st == CH_LATCH) || (c.st == CH_RETRY))
          c.st = CH_OFF;
        c.dur        = '0;
        c.phase      = PH_NONE;
        c.retries    = st.general_config_register.retry_limit;
        c.first_done = 1'b0;
      end

      if (st.s2.logic_loss)
      begin
        c.oc = 1'b0;
        c.sc = 1'b0;
        c.ot = 1'b0;
        if ((c.st == CH_LATCH) || (c.st == CH_RETRY))
          c.st = CH_OFF;
      end

      c.out_on = (c.st == CH_ON);
      c.sync   = !c.out_on || (c.phase == PH_HIGH) || (c.phase == PH_MID) ||
                 (prof && st.s2.oc_low[i]);
      any_fault = any_fault | (c.st == CH_RETRY) | (c.st == CH_LATCH);
      nx.ch[i]  = c;
    end

    // Shared supply flags: clear first, set wins
    if (st.s2.logic_loss)
    begin
      nx.ov = 1'b0;
      nx.uv = 1'b0;
    end
    if (rd_status_w && !st.ov_hold && !st.s2.ov)
      nx.ov = 1'b0;
    if (!st.s2.uv && (any_on || (rd_status_w && !any_latch)))
      nx.uv = 1'b0;
    if (st.s2.ov)
      nx.ov = 1'b1;
    if (st.s2.uv)
      nx.uv = 1'b1;

    nx.fsb_n = !(any_fault || st.s2.uv || ov_block || (|st.s2.ot));
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      st                         <= '0;
      st.fsb_n                   <= 1'b1;
      st.hreadyout               <= 1'b1;
      st.general_config_register.retry_limit         <= RETRY_LIMIT_RST;
      st.win.high_window_width   <= WIN_HI_RST;
      st.win.middle_window_width <= WIN_MID_RST;
      for (int i = 0; i < NCH; i++)
      begin
        st.ch[i].retries <= RETRY_LIMIT_RST;
        st.ch[i].sync    <= 1'b1;
      end
    end
    else
      st <= nx;
  end

  assign O_HRDATA             = st.hrdata;
  assign O_HREADYOUT          = st.hreadyout;
  assign O_HRESP              = st.hresp;
  assign O_FAULT_STATUS_OUT_N = st.fsb_n;
  assign O_CH_ON              = {st.ch[1].out_on, st.ch[0].out_on};
  assign O_SENSE_SYNC         = {st.ch[1].sync, st.ch[0].sync};

  // Checks
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_B);

  property p_oc_off;
    $rose(st.ch[0].oc) |-> !O_CH_ON[0] && !O_FAULT_STATUS_OUT_N;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("Overcurrent left channel on");

  property p_window_sync;
    st.ch[0].out_on && ((st.ch[0].phase == PH_HIGH) || (st.ch[0].phase == PH_MID))
      |-> O_SENSE_SYNC[0];
  endproperty
  a_window_sync: assert property (p_window_sync) else $error("Sync low in window");

  property p_retry_before_latch;
    $rose(st.ch[0].oc) && $past(st.general_config_register.retry_en[0]) && ($past(st.ch[0].retries) != '0)
      |-> st.ch[0].st == CH_RETRY;
  endproperty
  a_retry_before_latch: assert property (p_retry_before_latch) else $error("Early latch");

  property p_delatch_clr;
    delatch_w[0] |=> st.ch[0].dur == '0;
  endproperty
  a_delatch_clr: assert property (p_delatch_clr) else $error("Counter kept on delatch");

  property p_sc_off;
    $rose(st.ch[0].sc) |-> !O_CH_ON[0] && !O_FAULT_STATUS_OUT_N;
  endproperty
  a_sc_off: assert property (p_sc_off) else $error("Short left channel on");

  property p_ov_off;
    !st.general_config_register.overvoltage_protect_disable && st.s2.ov
      |=> (O_CH_ON == '0) && !O_FAULT_STATUS_OUT_N && st.ov;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("Overvoltage not handled");

  property p_ov_read;
    rd_status_w && !st.ov_hold && !st.s2.ov |=> !st.ov;
  endproperty
  a_ov_read: assert property (p_ov_read) else $error("Overvoltage flag kept");

  property p_ov_warn;
    st.general_config_register.overvoltage_protect_disable && st.s2.ov && (st.ch[0].st == CH_ON) &&
    st.s2.on_cmd[0] && !st.s2.uv && !(|st.s2.ot) && !(|st.s2.sc) && !(|st.s2.oc_high) &&
    !(|st.s2.oc_mid) && !(|st.s2.oc_low) |=> st.ov && st.ch[0].out_on;
  endproperty
  a_ov_warn: assert property (p_ov_warn) else $error("Disabled overvoltage acted");

  property p_uv_off;
    st.s2.uv |=> (O_CH_ON == '0) && !O_FAULT_STATUS_OUT_N && st.uv;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("Undervoltage not handled");

  property p_uv_clear_on;
    st.uv && !st.s2.uv && !st.s2.logic_loss && (|O_CH_ON) |=> !st.uv;
  endproperty
  a_uv_clear_on: assert property (p_uv_clear_on) else $error("Undervoltage flag kept");

  c_oc_retry: cover property ($rose(st.ch[0].oc) && (st.ch[0].st == CH_RETRY));
  c_latch:    cover property ($rose(st.ch[0].st == CH_LATCH));
  c_ov:       cover property ($rose(st.ov_hold) && !st.general_config_register.overvoltage_protect_disable);
  c_switch:   cover property ($rose(st.ch[0].switch_mode));

endmodule

// [bench/hsfp_load_model.sv]
// Output stage and load model: current comparators and hard short per channel.
// Assumes the bench sets a current level (0 none .. 3 high) and a short flag.
`timescale 1ns/1ps

module hsfp_load_model
  import hsfp_pkg::*;
(
  input  wire logic [NCH-1:0]   i_ch_on,
  input  wire logic [2*NCH-1:0] i_level,
  input  wire logic [NCH-1:0]   i_short,
  output logic      [NCH-1:0]   o_oc_high,
  output logic      [NCH-1:0]   o_oc_mid,
  output logic      [NCH-1:0]   o_oc_low,
  output logic      [NCH-1:0]   o_severe
);
  // No current flows while a channel is off
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      o_oc_low[c]  = i_ch_on[c] && (i_level[2*c+:2] >= 2'h1);
      o_oc_mid[c]  = i_ch_on[c] && (i_level[2*c+:2] >= 2'h2);
      o_oc_high[c] = i_ch_on[c] && (i_level[2*c+:2] == 2'h3);
      o_severe[c]  = i_ch_on[c] && i_short[c];
    end
  end
endmodule

// [bench/hsfp_top_tb.sv]
// Bench for the fault protection block: bus tasks and one task a scenario.
// Assumes a zero wait state slave and the behavioural load model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end

module hsfp_top_tb
  import hsfp_pkg::*;
;
  logic             clk, rst_b, sel, hw, ov, ovr, uv, rdy, resp, fault_n;
  logic [1:0]       tr;
  logic [31:0]      ad, wd, rdat, rd_v;
  logic [NCH-1:0]   cmd, prof, shrt, och, ocm, ocl, sev, on, sync;
  logic [2*NCH-1:0] lvl;
  int               num_errors = 0;
  int               checked = 0;

  hsfp_top #(.RETRY_WAIT_CYC(24'd20), .PWM_MAX_PERIOD_CYC(24'd50)) dut (
    .I_MCLK(clk), .I_RST_B(rst_b), .I_HSEL(sel), .I_HADDR(ad), .I_HTRANS(tr),
    .I_HWRITE(hw), .I_HSIZE(3'h2), .I_HWDATA(wd), .I_HREADY(rdy),
    .O_HRDATA(rdat), .O_HREADYOUT(rdy), .O_HRESP(resp), .I_ON_CMD(cmd),
    .I_LOAD_PROFILE_SELECT(prof), .I_OC_HIGH(och), .I_OC_MID(ocm), .I_OC_LOW(ocl),
    .I_SEVERE_SHORT(sev), .I_OVERTEMP(2'h0), .I_SUPPLY_OV(ov),
    .I_SUPPLY_OV_RELEASE(ovr), .I_SUPPLY_UV(uv), .I_LOGIC_SUPPLY_LOSS(1'b0),
    .O_CH_ON(on), .O_SENSE_SYNC(sync), .O_FAULT_STATUS_OUT_N(fault_n));

  hsfp_load_model load (.i_ch_on(on), .i_level(lvl), .i_short(shrt),
    .o_oc_high(och), .o_oc_mid(ocm), .o_oc_low(ocl), .o_severe(sev));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    sel <= 1'b1; tr <= 2'h2; hw <= w; ad <= a;
    do @(posedge clk); while (rdy !== 1'b1);
    sel <= 1'b0; tr <= 2'h0; wd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd_v = rdat;
    `CHK("resp", 1'b0, resp)
  endtask

  task automatic rchk(input string n, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, rd_v)
  endtask

  task automatic clean(input string n);
    cmd <= 2'h0; lvl <= 4'h0; shrt <= 2'h0;
    cyc(60);
    bus(1'b1, 32'h8, 32'h3);
    bus(1'b0, 32'hc, 32'h0);
    bus(1'b0, 32'hc, 32'h0);
    `CHK("flags clr", 4'h0, rd_v[5:2])
    $display("test %s done", n);
  endtask

  task automatic t_reset();
    `CHK("on", 2'h0, on)
    `CHK("sync", 2'h3, sync)
    `CHK("fault", 1'b1, fault_n)
    rchk("gcr", 32'h0, 32'h30);
    rchk("win", 32'h4, 32'h9c400fa0);
    rchk("delatch", 32'h8, 32'h0);
    rchk("unmapped", 32'h10, 32'h0);
    rchk("status", 32'hc, 32'h33000);
    bus(1'b1, 32'h4, 32'h00140004);
    rchk("win wr", 32'h4, 32'h00140004);
    $display("test reset done");
  endtask

  task automatic t_light();
    prof <= 2'h0; lvl <= 4'h3; cmd <= 2'h1;
    cyc(12);
    `CHK("off hi", 1'b0, on[0])
    `CHK("fault oc", 1'b0, fault_n)
    bus(1'b0, 32'hc, 32'h0);
    `CHK("oc flag", 1'b1, rd_v[2])
    clean("light high");
    lvl <= 4'h1; cmd <= 2'h1;
    cyc(10);
    `CHK("on mid", 1'b1, on[0])
    `CHK("blank", 1'b1, sync[0])
    cyc(35);
    `CHK("off low", 1'b0, on[0])
    clean("light low");
  endtask

  task automatic t_motor();
    prof <= 2'h2; lvl <= 4'h4; cmd <= 2'h2;
    cyc(12);
    `CHK("dc on", 1'b1, on[1])
    `CHK("dc blank", 1'b1, sync[1])
    cyc(33);
    `CHK("dc off", 1'b0, on[1])
    bus(1'b0, 32'hc, 32'h0);
    `CHK("dc oc", 1'b1, rd_v[3])
    clean("motor");
  endtask

  task automatic t_retry();
    prof <= 2'h0;
    bus(1'b1, 32'h0, 32'h12);
    lvl <= 4'h3; cmd <= 2'h1;
    cyc(150);
    bus(1'b0, 32'hc, 32'h0);
    `CHK("ret left", 4'h0, rd_v[15:12])
    `CHK("ret latch", 2'h1, rd_v[3:2])
    bus(1'b1, 32'h0, 32'h30);
    clean("retry");
  endtask

  task automatic t_short();
    shrt <= 2'h1; cmd <= 2'h1;
    cyc(15);
    `CHK("sc off", 1'b0, on[0])
    `CHK("sc fault", 1'b0, fault_n)
    bus(1'b0, 32'hc, 32'h0);
    `CHK("sc flag", 1'b1, rd_v[4])
    clean("short");
  endtask

  task automatic t_ov();
    cmd <= 2'h3;
    cyc(10);
    ov <= 1'b1; ovr <= 1'b0;
    cyc(6);
    `CHK("ov off", 2'h0, on)
    `CHK("ov fault", 1'b0, fault_n)
    ov <= 1'b0; ovr <= 1'b1;
    cyc(8);
    `CHK("ov back", 2'h3, on)
    bus(1'b0, 32'hc, 32'h0);
    `CHK("ov flag", 1'b1, rd_v[0])
    bus(1'b0, 32'hc, 32'h0);
    `CHK("ov clr", 1'b0, rd_v[0])
    bus(1'b1, 32'h0, 32'h31);
    ov <= 1'b1; ovr <= 1'b0;
    cyc(6);
    `CHK("ov kept", 2'h3, on)
    `CHK("ov quiet", 1'b1, fault_n)
    bus(1'b0, 32'hc, 32'h0);
    `CHK("ov warn", 1'b1, rd_v[0])
    ov <= 1'b0; ovr <= 1'b1;
    bus(1'b1, 32'h0, 32'h30);
    clean("ov");
  endtask

  task automatic t_uv();
    uv <= 1'b1;
    cyc(6);
    `CHK("uv fault", 1'b0, fault_n)
    bus(1'b0, 32'hc, 32'h0);
    `CHK("uv flag", 1'b1, rd_v[1])
    uv <= 1'b0;
    cyc(6);
    `CHK("uv gone", 1'b1, fault_n)
    cmd <= 2'h3;
    cyc(8);
    uv <= 1'b1;
    cyc(6);
    `CHK("uv off", 2'h0, on)
    uv <= 1'b0;
    cyc(10);
    `CHK("uv stay", 2'h0, on)
    clean("uv");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #(5 * 20000);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    {rst_b, sel, hw, ov, uv, tr, ad, wd, cmd, prof, shrt, lvl} = '0;
    ovr = 1'b1;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    cyc(1);
    t_reset();
    t_light();
    t_motor();
    t_retry();
    t_short();
    t_ov();
    t_uv();
    print_verdict();
  end
endmodule
